// [hw/cprg_top.sv]
// Clock select, PLL control and system reset generation
//
// Summary of operation
// - PLL output equals reference times an integer factor from 4 to 15.
// - PLL output times PWM when selected; core clock is divided from the I_MCLK reference.
// - Until configured and locked, system runs from the crystal reference.
// - Separate generators make core, S/PDIF, converter and master-out clocks.
// - Power-on reset pulse when PLL supply rises to threshold.
// - After a PLL supply sag, a new pulse follows recovery.
// - Power-on reset drives the reset status pin low.
// - Either brown-out detector drives the reset status pin low.
// - System reset from external reset low or power-on pulse.
// - Counter stretches internal reset after external reset release.
// - Brown-out holds power-on reset until both supplies are safe.
// - Brown-out while running shuts amplifier outputs down safely.
// - In reset: system reset and status pin active, test reset kept apart, oscillator runs, PLL disabled.
// - External reset initialises all state except test hardware.
`timescale 1ns/1ps
`include "cprg_consts.svh"
module cprg_top #(
   parameter int STRETCH_CYC = `CPRG_STRETCH_CYC,
   parameter int POR_CYC     = `CPRG_POR_PULSE_CYC,
   parameter int DIV_W       = `CPRG_DIV_W
) (
   // Clock (crystal reference domain) and external reset pin
   input  wire logic                        I_MCLK,
   input  wire logic                        I_RST_B,
   // Test hardware reset, kept apart from the functional reset
   input  wire logic                        I_TEST_RST_B,
   // Asynchronous supply sensors, high when rail is below threshold
   input  wire logic                        I_PLL_SUPPLY_RAIL_LOW,
   input  wire logic                        I_CORE_SUPPLY_RAIL_LOW,
   input  wire logic                        I_PWM_SUPPLY_RAIL_LOW,
   // Firmware clock configuration
   input  wire cprg_pkg::cprg_cfg_t         I_CFG,
   input  wire logic [DIV_W-1:0]            I_CORE_DIV,
   input  wire logic [DIV_W-1:0]            I_SPDIF_DIV,
   input  wire logic [DIV_W-1:0]            I_CONV_DIV,
   input  wire logic [DIV_W-1:0]            I_MCLKOUT_DIV,
   // Analog PLL macro interface
   input  wire logic                        I_PLL_LOCK,
   input  wire logic                        I_PLL_CLK_TICK,
   output logic                             O_PLL_EN,
   output logic [`CPRG_MULT_W-1:0]          O_PLL_MULT,
   // Clock selection and derived clocks
   output logic                             O_SYS_SEL_PLL,
   output logic                             O_OSC_RUN,
   output logic                             O_PWM_TICK,
   output logic                             O_CORE_CLK,
   output logic                             O_SPDIF_CLK,
   output logic                             O_CONV_CLK,
   output logic                             O_MCLKOUT_CLK,
   // Resets and status
   output logic                             O_SYS_RST_B,
   output logic                             O_TEST_RST_B,
   output logic                             O_RESET_STATUS_OUT_LOW,
   output logic                             O_AMP_SHUTDOWN,
   output cprg_pkg::cprg_state_t            O_STATE
);
   initial begin
      if (STRETCH_CYC < 2 || STRETCH_CYC > 65535) $error("cprg_top: bad STRETCH_CYC");
      if (POR_CYC < 1 || POR_CYC > 255) $error("cprg_top: bad POR_CYC");
      if (DIV_W < 2) $error("cprg_top: bad DIV_W");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronisers for asynchronous sensor inputs
   cprg_pkg::cprg_sense_t sense_meta_ff;
   cprg_pkg::cprg_sense_t sense_ff;
   logic [1:0]            lock_sync_ff;
   wire  cprg_pkg::cprg_sense_t sense_raw = '{pll_low:  I_PLL_SUPPLY_RAIL_LOW,
                                              core_low: I_CORE_SUPPLY_RAIL_LOW,
                                              pwm_low:  I_PWM_SUPPLY_RAIL_LOW};
   // Supplies start as low so that power-on always yields a pulse
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         sense_meta_ff <= 3'h7;
         sense_ff      <= 3'h7;
         lock_sync_ff  <= 2'h0;
      end else begin
         sense_meta_ff <= sense_raw;
         sense_ff      <= sense_meta_ff;
         lock_sync_ff  <= {lock_sync_ff[0], I_PLL_LOCK};
      end
   end
   // Lock comes from the analog macro, unrelated to this clock's phase
   wire pll_locked = lock_sync_ff[1];
   wire brown_out  = sense_ff.core_low | sense_ff.pwm_low;

   ////////////////////////////////////////////////////////////////////////////////
   // Power-on reset pulse on each rise of the PLL supply
   logic       pll_low_d_ff;
   logic [7:0] por_cnt_ff;
   wire        por_busy = (por_cnt_ff != 8'h00);
   wire        pll_rise = pll_low_d_ff & ~sense_ff.pll_low;
   wire [7:0]  nxt_por_cnt = pll_rise ? 8'(POR_CYC) :
                             por_busy ? por_cnt_ff - 8'h01 : 8'h00;
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         pll_low_d_ff <= 1'b1;
         por_cnt_ff   <= 8'h00;
      end else begin
         pll_low_d_ff <= sense_ff.pll_low;
         por_cnt_ff   <= nxt_por_cnt;
      end
   end
   // Brown-out holds power-on reset until both rails recover
   wire por_active = por_busy | pll_rise | brown_out;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset stretch counter; the async pin asserts at once, release is
   // counted on the clock so deassertion is never metastable
   logic [15:0] stretch_ff;
   logic        sys_rst_b_ff;
   wire         rst_req   = por_active;
   wire         stretch_done = (stretch_ff == 16'(STRETCH_CYC - 1));
   wire [15:0]  nxt_stretch = rst_req ? 16'h0000 :
                              stretch_done ? stretch_ff : stretch_ff + 16'h0001;
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         stretch_ff   <= 16'h0000;
         sys_rst_b_ff <= 1'b0;
      end else begin
         stretch_ff   <= nxt_stretch;
         sys_rst_b_ff <= stretch_done & ~rst_req;
      end
   end
   assign O_SYS_RST_B  = sys_rst_b_ff;
   // Test hardware has its own reset and ignores the functional pin
   assign O_TEST_RST_B = I_TEST_RST_B;
   assign O_OSC_RUN    = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Reset status pin and amplifier shutdown
   logic rstout_b_ff;
   logic amp_shut_ff;
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         rstout_b_ff <= 1'b0;
         amp_shut_ff <= 1'b1;
      end else begin
         rstout_b_ff <= ~por_active;
         amp_shut_ff <= brown_out | ~sys_rst_b_ff;
      end
   end
   assign O_RESET_STATUS_OUT_LOW = rstout_b_ff;
   assign O_AMP_SHUTDOWN         = amp_shut_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Multiplier: firmware value clamped to the legal span
   logic [3:0] mult_ff;
   wire        mult_ok  = (I_CFG.mult >= `CPRG_MULT_MIN);
   wire [3:0]  nxt_mult = mult_ok ? I_CFG.mult : `CPRG_MULT_MIN;
   ////////////////////////////////////////////////////////////////////////////////
   // Firmware asks for the PLL and the synchronised lock agrees
   function automatic logic cprg_fw_go(input cprg_pkg::cprg_cfg_t cfg, input logic locked);
      return cfg.pll_en && cfg.use_pll && locked;
   endfunction : cprg_fw_go
   wire fw_go = cprg_fw_go(I_CFG, pll_locked);
   ////////////////////////////////////////////////////////////////////////////////
   // Clock source state machine. The PLL is re-selected only from bypass,
   // so a multiplier change while on the PLL falls back first.
   cprg_pkg::cprg_state_t state_ff;
   cprg_pkg::cprg_state_t nxt_state;
   logic [1:0]            sw_cnt_ff;
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         cprg_pkg::CPRG_ST_RESET: begin
            if (sys_rst_b_ff) nxt_state = cprg_pkg::CPRG_ST_BYPASS;
         end
         cprg_pkg::CPRG_ST_BYPASS: begin
            // Firmware request and synchronised lock together start the change
            if (fw_go)
               nxt_state = cprg_pkg::CPRG_ST_SWITCH;
         end
         cprg_pkg::CPRG_ST_SWITCH: begin
            // Lock must stay up through the whole settle window
            if (!fw_go)
               nxt_state = cprg_pkg::CPRG_ST_BYPASS;
            else if (sw_cnt_ff == 2'h3) nxt_state = cprg_pkg::CPRG_ST_PLL;
         end
         cprg_pkg::CPRG_ST_PLL: begin
            if (!fw_go || (nxt_mult != mult_ff))
               nxt_state = cprg_pkg::CPRG_ST_BYPASS;
         end
         default: nxt_state = cprg_pkg::CPRG_ST_RESET;
      endcase
      // A reset request drops the PLL at once, so select and reset fall together
      if (!sys_rst_b_ff || rst_req) nxt_state = cprg_pkg::CPRG_ST_RESET;
   end
   wire [1:0] nxt_sw_cnt = (state_ff == cprg_pkg::CPRG_ST_SWITCH) ? sw_cnt_ff + 2'h1 : 2'h0;
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_ff  <= cprg_pkg::CPRG_ST_RESET;
         sw_cnt_ff <= 2'h0;
         mult_ff   <= `CPRG_MULT_RST;
      end else begin
         state_ff  <= nxt_state;
         sw_cnt_ff <= nxt_sw_cnt;
         mult_ff   <= (state_ff == cprg_pkg::CPRG_ST_PLL) ? mult_ff : nxt_mult;
      end
   end
   assign O_STATE    = state_ff;
   assign O_PLL_MULT = mult_ff;
   assign O_PLL_EN   = sys_rst_b_ff & I_CFG.pll_en;

   ////////////////////////////////////////////////////////////////////////////////
   // Registered select; the gating cell downstream changes on a quiet
   // phase, so the select is held stable for the switch delay
   logic sel_pll_ff;
   always_ff @(posedge I_MCLK or negedge I_RST_B) begin
      if (!I_RST_B) sel_pll_ff <= 1'b0;
      else sel_pll_ff <= (nxt_state == cprg_pkg::CPRG_ST_PLL);
   end
   assign O_SYS_SEL_PLL = sel_pll_ff;
   // PWM timing follows the PLL when selected, else the reference
   assign O_PWM_TICK    = sel_pll_ff ? I_PLL_CLK_TICK : 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // Four independent derived clock generators
   wire [DIV_W-1:0] div_sel [4];
   wire             clk_out [4];
   assign div_sel[0] = I_CORE_DIV;
   assign div_sel[1] = I_SPDIF_DIV;
   assign div_sel[2] = I_CONV_DIV;
   assign div_sel[3] = I_MCLKOUT_DIV;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_div
         cprg_clk_div #(.DW(DIV_W)) u_div (
            .I_MCLK  (I_MCLK),
            .i_rst_b (sys_rst_b_ff),
            .i_div   (div_sel[g]),
            .o_tick  (),
            .o_clk   (clk_out[g])
         );
      end
   endgenerate
   assign O_CORE_CLK    = clk_out[0];
   assign O_SPDIF_CLK   = clk_out[1];
   assign O_CONV_CLK    = clk_out[2];
   assign O_MCLKOUT_CLK = clk_out[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   pll_after_lock_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      sel_pll_ff |-> lock_sync_ff[1] || $past(lock_sync_ff[1]))
      else $error("PLL selected without lock");
   bypass_unlock_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      (!pll_locked && !sel_pll_ff) |=> !sel_pll_ff)
      else $error("PLL selected while unlocked");
   por_pulse_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      pll_rise |=> !rstout_b_ff [*2])
      else $error("No status low after supply rise");
   repeat_pulse_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      $fell(sense_ff.pll_low) |-> ##1 por_cnt_ff == 8'(POR_CYC))
      else $error("No new pulse after sag");
   status_por_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      (por_cnt_ff != 8'h00) |=> !rstout_b_ff)
      else $error("Status high during power-on reset");
   status_bo_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      brown_out |=> !rstout_b_ff && !sys_rst_b_ff)
      else $error("Status high during brown-out");
   bo_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      brown_out |=> stretch_ff == 16'h0000)
      else $error("Stretch runs during brown-out");
   amp_shut_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      brown_out |=> amp_shut_ff)
      else $error("Amplifier not shut down");
   stretch_len_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      $rose(sys_rst_b_ff) |-> $past(stretch_ff) == 16'(STRETCH_CYC - 1))
      else $error("Reset released early");
   pll_off_rst_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      !sys_rst_b_ff |-> !O_PLL_EN && !sel_pll_ff)
      else $error("PLL active in reset");
   mult_range_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      mult_ff >= `CPRG_MULT_MIN)
      else $error("Multiplier out of range");
   cov_release_c: cover property (@(posedge I_MCLK) disable iff (!I_RST_B) $rose(sys_rst_b_ff));
   cov_to_pll_c: cover property (@(posedge I_MCLK) disable iff (!I_RST_B) $rose(sel_pll_ff));
   cov_bo_c: cover property (@(posedge I_MCLK) disable iff (!I_RST_B) sel_pll_ff ##1 brown_out);
   cov_sag_c: cover property (@(posedge I_MCLK) disable iff (!I_RST_B) pll_rise && sys_rst_b_ff);
   cov_mult_c: cover property (@(posedge I_MCLK) disable iff (!I_RST_B)
      (state_ff == cprg_pkg::CPRG_ST_PLL) && (nxt_mult != mult_ff));
   rst_req_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      rst_req |=> !sys_rst_b_ff && state_ff == cprg_pkg::CPRG_ST_RESET)
      else $error("Reset request not obeyed");
   stretch_hold_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      (!sys_rst_b_ff && !stretch_done) |=> !sys_rst_b_ff)
      else $error("Reset released before count ends");
   switch_wait_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      $rose(sel_pll_ff) |-> $past(state_ff, 4) == cprg_pkg::CPRG_ST_SWITCH)
      else $error("PLL selected before switch delay");
   pwm_ref_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      !sel_pll_ff |-> O_PWM_TICK)
      else $error("PWM tick not on reference");
   pwm_follow_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      sel_pll_ff |-> O_PWM_TICK == I_PLL_CLK_TICK)
      else $error("PWM tick not on PLL");
   div_rst_a: assert property (@(posedge I_MCLK) disable iff (!I_RST_B)
      !sys_rst_b_ff |-> !O_CORE_CLK && !O_SPDIF_CLK && !O_CONV_CLK && !O_MCLKOUT_CLK)
      else $error("Derived clock runs in reset");
endmodule : cprg_top

// [hw/cprg_consts.svh]
// Constants for the clock and reset generation unit
`ifndef CPRG_CONSTS_SVH
`define CPRG_CONSTS_SVH
`define CPRG_MULT_W        4
`define CPRG_MULT_MIN      4'h4
`define CPRG_MULT_MAX      4'hF
`define CPRG_MULT_RST      4'h4
`define CPRG_STRETCH_CYC   256
`define CPRG_POR_PULSE_CYC 16
`define CPRG_DIV_W         8
`endif

// [hw/cprg_pkg.sv]
// Types for the clock and reset generation unit
package cprg_pkg;
   // Sensor indications, synchronised, active high for a problem
   typedef struct packed {
      logic pll_low;
      logic core_low;
      logic pwm_low;
   } cprg_sense_t;
   // Firmware clock configuration
   typedef struct packed {
      logic [3:0] mult;
      logic       pll_en;
      logic       use_pll;
   } cprg_cfg_t;
   typedef enum logic [3:0] {
      CPRG_ST_RESET  = 4'h1,
      CPRG_ST_BYPASS = 4'h2,
      CPRG_ST_SWITCH = 4'h4,
      CPRG_ST_PLL    = 4'h8
   } cprg_state_t;
endpackage : cprg_pkg

// [hw/cprg_clk_div.sv]
// Free running clock generator: divide-by-N enable pulse and square wave
`timescale 1ns/1ps
module cprg_clk_div #(
   parameter int DW = 8
) (
   // Clock and reset
   input  wire logic          I_MCLK,
   input  wire logic          i_rst_b,
   // Divide ratio, 0 and 1 tick every cycle and give the same square wave as 2
   input  wire logic [DW-1:0] i_div,
   // Outputs
   output logic               o_tick,
   output logic               o_clk
);
   initial begin
      if (DW < 2) $error("cprg_clk_div: DW must be at least 2");
   end
   logic [DW-1:0] cnt_ff;
   logic          tick_ff;
   logic          clk_ff;
   wire           wrap = (cnt_ff >= i_div - DW'(1)) || (i_div < DW'(2));
   wire  [DW-1:0] nxt_cnt = wrap ? '0 : cnt_ff + DW'(1);
   wire           nxt_clk = (i_div < DW'(2)) ? ~clk_ff : (cnt_ff < (i_div >> 1));
   // Counter and registered outputs
   always_ff @(posedge I_MCLK or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_ff  <= '0;
         tick_ff <= 1'b0;
         clk_ff  <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         tick_ff <= wrap;
         clk_ff  <= nxt_clk;
      end
   end
   assign o_tick = tick_ff;
   assign o_clk  = clk_ff;
endmodule : cprg_clk_div

// [verification/cprg_pll_model.sv]
// Behavioural model of the analog PLL macro that faces the clock unit
`timescale 1ns/1ps
module cprg_pll_model #(
   parameter int LOCK_CYC = 6
) (
   // Reference clock and board reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_b,
   // Control from the clock unit
   input  wire logic       i_en,
   input  wire logic [3:0] i_mult,
   // Bench command: lose lock on purpose
   input  wire logic       i_drop,
   // Lock flag and output clock ticks
   output logic            o_lock,
   output logic            o_tick
);
   int         cnt;
   logic [3:0] mult_q;
   logic       ph;
   ////////////////////////////////////////////////////////////////////////////
   // Lock counter restarts when the multiplier moves, as a real loop must re-acquire
   always @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt <= 0;
         mult_q <= 4'h0;
         ph <= 1'b0;
      end else begin
         mult_q <= i_mult;
         ph <= ~ph;
         if (!i_en || i_drop || (i_mult != mult_q)) begin
            cnt <= 0;
         end else if (cnt < LOCK_CYC) begin
            cnt <= cnt + 1;
         end
      end
   end
   // Tick changes every cycle so a stale copy cannot pass; quiet while disabled
   assign o_lock = (cnt == LOCK_CYC);
   assign o_tick = i_en & ph;
endmodule : cprg_pll_model

// [verification/clock_pll_reset_gen_test.sv]
// Self-checking bench for the clock select and reset generation unit
`timescale 1ns/1ps
module clock_pll_reset_gen_test;
   localparam int STR = 8;
   localparam int POR = 2;
   logic                  clk, rst_b, test_rst_b, drop, lock, tick, pll_en, sel, osc_run;
   logic                  pwm_tick, core_clk, spdif_clk, conv_clk, mclkout_clk;
   logic                  sys_rst_b, test_rst_out_b, status_b, amp_off;
   logic [2:0]            rails;
   logic [3:0]            pll_mult;
   logic [7:0]            divs [4];
   cprg_pkg::cprg_cfg_t   cfg;
   cprg_pkg::cprg_state_t state;
   int                    num_errors = 0;
   int                    check_count = 0;
   ////////////////////////////////////////////////////////////////////////////
   cprg_top #(.STRETCH_CYC(STR), .POR_CYC(POR), .DIV_W(8)) DUT (
      .I_MCLK(clk), .I_RST_B(rst_b), .I_TEST_RST_B(test_rst_b),
      .I_PLL_SUPPLY_RAIL_LOW(rails[2]), .I_CORE_SUPPLY_RAIL_LOW(rails[1]),
      .I_PWM_SUPPLY_RAIL_LOW(rails[0]), .I_CFG(cfg), .I_CORE_DIV(divs[0]),
      .I_SPDIF_DIV(divs[1]), .I_CONV_DIV(divs[2]), .I_MCLKOUT_DIV(divs[3]),
      .I_PLL_LOCK(lock), .I_PLL_CLK_TICK(tick), .O_PLL_EN(pll_en), .O_PLL_MULT(pll_mult),
      .O_SYS_SEL_PLL(sel), .O_OSC_RUN(osc_run), .O_PWM_TICK(pwm_tick),
      .O_CORE_CLK(core_clk), .O_SPDIF_CLK(spdif_clk), .O_CONV_CLK(conv_clk),
      .O_MCLKOUT_CLK(mclkout_clk), .O_SYS_RST_B(sys_rst_b), .O_TEST_RST_B(test_rst_out_b),
      .O_RESET_STATUS_OUT_LOW(status_b), .O_AMP_SHUTDOWN(amp_off), .O_STATE(state));
   cprg_pll_model u_pll (.i_clk(clk), .i_rst_b(rst_b), .i_en(pll_en), .i_mult(pll_mult),
      .i_drop(drop), .o_lock(lock), .o_tick(tick));
   // Reference clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic wrap_up();
      $display("Checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : wrap_up
   // Conditions polled by the bounded wait
   function automatic logic cond(input int k);
      case (k)
         0: return sys_rst_b === 1'b1;
         1: return sel === 1'b1;
         default: return state === cprg_pkg::CPRG_ST_BYPASS;
      endcase
   endfunction : cond
   // Bounded wait; running out of cycles ends the run with a mismatch
   task automatic wait_for(input string what, input int k, input int bound);
      int n;
      n = 0;
      while (!cond(k) && n < bound) begin
         @(negedge clk);
         n++;
      end
      chk(what, {7'h00, cond(k)}, 8'h01);
      if (!cond(k)) wrap_up();
   endtask : wait_for
   task automatic set_cfg(input logic [3:0] m, input logic en, input logic use_pll);
      @(posedge clk);
      cfg <= '{mult: m, pll_en: en, use_pll: use_pll};
   endtask : set_cfg
   ////////////////////////////////////////////////////////////////////////////
   // Reset hold and stretched release
   task automatic t_reset();
      int n;
      repeat (12) @(negedge clk);
      chk("sys_rst_b", sys_rst_b, 8'h00);
      chk("status_b", status_b, 8'h00);
      chk("state", state, 8'h01);
      chk("pll_en", pll_en, 8'h00);
      chk("osc_run", osc_run, 8'h01);
      chk("sel", sel, 8'h00);
      chk("test_rst", test_rst_out_b, 8'h01);
      @(posedge clk);
      rst_b <= 1'b1;
      n = 0;
      while (sys_rst_b !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk("stretch_min", n >= STR, 8'h01);
      chk("stretch_max", n <= STR + POR + 10, 8'h01);
      chk("status_up", status_b, 8'h01);
      if (sys_rst_b !== 1'b1) wrap_up();
      @(posedge clk);
      test_rst_b <= 1'b0;
      @(negedge clk);
      chk("test_rst_own", test_rst_out_b, 8'h00);
      chk("sys_rst_kept", sys_rst_b, 8'h01);
      @(posedge clk);
      test_rst_b <= 1'b1;
      $display("test reset done");
   endtask : t_reset
   // Bypass until firmware asks and lock is seen, then PWM tick follows the PLL
   task automatic t_switch();
      set_cfg(4'hA, 1'b1, 1'b0);
      repeat (20) @(negedge clk);
      chk("pll_en", pll_en, 8'h01);
      chk("pll_mult", pll_mult, 8'h0A);
      chk("bypass", state, 8'h02);
      chk("pwm_tick_ref", pwm_tick, 8'h01);
      set_cfg(4'hA, 1'b1, 1'b1);
      wait_for("sel_rise", 1, 30);
      chk("state_pll", state, 8'h08);
      repeat (4) begin
         @(negedge clk);
         chk("pwm_tick", pwm_tick, tick);
      end
      $display("test switch done");
   endtask : t_switch
   // Lock loss and multiplier change both drop back to the reference
   task automatic t_fallback();
      @(posedge clk);
      drop <= 1'b1;
      wait_for("lock_loss", 2, 10);
      chk("sel_drop", sel, 8'h00);
      @(posedge clk);
      drop <= 1'b0;
      wait_for("relock", 1, 40);
      set_cfg(4'hC, 1'b1, 1'b1);
      wait_for("mult_fall", 2, 10);
      wait_for("mult_relock", 1, 40);
      chk("pll_mult_c", pll_mult, 8'h0C);
      $display("test fallback done");
   endtask : t_fallback
   // Each rail sag while running: reset, status low, amplifier off, then recovery
   task automatic t_rails();
      logic saw_st, saw_rst, saw_off;
      for (int r = 0; r < 3; r++) begin
         saw_st = 1'b0;
         saw_rst = 1'b0;
         saw_off = 1'b0;
         wait_for("running", 1, 60);
         @(posedge clk);
         rails <= 3'h1 << r;
         repeat (12) @(posedge clk);
         rails <= 3'h0;
         repeat (8) begin
            @(negedge clk);
            saw_st = saw_st | (status_b === 1'b0);
            saw_rst = saw_rst | (sys_rst_b === 1'b0);
            saw_off = saw_off | (amp_off === 1'b1);
         end
         chk("rail_status", saw_st, 8'h01);
         chk("rail_sysrst", saw_rst, 8'h01);
         chk("rail_amp_off", saw_off, 8'h01);
         wait_for("rail_recover", 0, STR + POR + 40);
         chk("rail_sel", sel, 8'h00);
      end
      $display("test rails done");
   endtask : t_rails
   // Multiplier range 4 to 15, lower settings clamp to 4
   task automatic t_mult();
      set_cfg(4'h4, 1'b1, 1'b0);
      wait_for("bypass", 2, 10);
      for (int m = 0; m < 16; m++) begin
         set_cfg(4'(m), 1'b1, 1'b0);
         repeat (3) @(negedge clk);
         chk("mult", pll_mult, (m < 4) ? 8'h04 : 8'(m));
      end
      $display("test mult done");
   endtask : t_mult
   // Four generators at different ratios run apart from each other
   task automatic t_divs();
      int c[4];
      logic [3:0] prev, now;
      c = '{0, 0, 0, 0};
      @(posedge clk);
      divs <= '{8'h02, 8'h04, 8'h08, 8'h10};
      repeat (40) @(negedge clk);
      prev = {core_clk, spdif_clk, conv_clk, mclkout_clk};
      repeat (128) begin
         @(negedge clk);
         now = {core_clk, spdif_clk, conv_clk, mclkout_clk};
         for (int i = 0; i < 4; i++) c[i] += (now[3 - i] !== prev[3 - i]);
         prev = now;
      end
      chk("core_vs_spdif", c[0] > c[1], 8'h01);
      chk("spdif_vs_conv", c[1] > c[2], 8'h01);
      chk("conv_vs_mclk", c[2] > c[3] && c[3] > 0, 8'h01);
      $display("test dividers done");
   endtask : t_divs
   // External reset in mid-run overrides the PLL selection at once
   task automatic t_ext_reset();
      set_cfg(4'h7, 1'b1, 1'b1);
      wait_for("sel_again", 1, 60);
      @(posedge clk);
      rst_b <= 1'b0;
      @(negedge clk);
      chk("mid_state", state, 8'h01);
      chk("mid_sel", sel, 8'h00);
      chk("mid_pll_en", pll_en, 8'h00);
      chk("mid_sysrst", sys_rst_b, 8'h00);
      chk("mid_test", test_rst_out_b, 8'h01);
      @(posedge clk);
      rst_b <= 1'b1;
      wait_for("mid_release", 0, STR + POR + 40);
      $display("test external reset done");
   endtask : t_ext_reset
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_b = 1'b0;
      test_rst_b = 1'b1;
      drop = 1'b0;
      rails = 3'h0;
      cfg = '{mult: 4'h4, pll_en: 1'b1, use_pll: 1'b0};
      divs = '{8'h01, 8'h01, 8'h01, 8'h01};
      t_reset();
      t_switch();
      t_fallback();
      t_rails();
      t_mult();
      t_divs();
      t_ext_reset();
      wrap_up();
   end
endmodule : clock_pll_reset_gen_test
